// ---- shared/fgam_regs.svh ----
/*
  Global address constants for the flash address decoder.
  Assumes 23-bit global addresses and byte-wide data.
*/
`ifndef FGAM_REGS_SVH
`define FGAM_REGS_SVH

// ----------------------------------------------------------------
// Window bounds
// ----------------------------------------------------------------
`define FGAM_PF_BASE 23'h7F0000
`define FGAM_PF_TOP 23'h7FFFFF
`define FGAM_PF_LO_BASE 17'h08000
`define FGAM_PF_END 17'h10000
`define FGAM_CFG_BASE 23'h7FFF00
`define FGAM_CFG_TOP 23'h7FFF0F
`define FGAM_PIF_BASE 23'h400000
`define FGAM_PIF_TOP 23'h4001FF
`define FGAM_ONCE_BASE 23'h400100
`define FGAM_ONCE_TOP 23'h40013F
`define FGAM_DF_BASE 23'h100000
`define FGAM_DF_TOP 23'h100FFF
`define FGAM_DF_RSV_TOP 23'h11FFFF
`define FGAM_DIF_BASE 23'h120000
`define FGAM_DIF_TOP 23'h12007F
`define FGAM_RAM_BASE 23'h123D00
`define FGAM_RAM_TOP 23'h123FFF

// ----------------------------------------------------------------
// Configuration field byte offsets
// ----------------------------------------------------------------
`define FGAM_KEY_LAST 4'h7
`define FGAM_OFS_PPROT 4'hC
`define FGAM_OFS_DPROT 4'hD
`define FGAM_OFS_OPT 4'hE
`define FGAM_OFS_SEC 4'hF
`define FGAM_ERASED 8'hFF

// ----------------------------------------------------------------
// Protection byte fields
// ----------------------------------------------------------------
`define FGAM_FP_OPEN 7
`define FGAM_FP_HDIS 5
`define FGAM_FP_HS_HI 4
`define FGAM_FP_HS_LO 3
`define FGAM_FP_LDIS 2
`define FGAM_FP_LS_HI 1
`define FGAM_FP_LS_LO 0

`endif

// ---- shared/fgam_pkg.sv ----
/*
  Types for the flash address decoder.
  Assumes fgam_regs.svh sits on the include path.
*/
package fgam_pkg;

  // Window hit flags, one per decoded area
  typedef struct packed {
    logic pflash;
    logic cfg;
    logic pgm_ifr;
    logic pgm_once;
    logic dflash;
    logic dflash_ifr;
    logic scratch;
    logic unmapped;
  } fgam_hit_t;

  // One bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic prog;
    logic [22:0] addr;
    logic [7:0] wdata;
  } fgam_req_t;

  // Visibility bits of memory map control one
  typedef struct packed {
    logic program_info_row_visible;
    logic dflash_info_row_visible;
    logic scratch_ram_visible;
  } fgam_vis_t;

endpackage : fgam_pkg

// ---- verilog/fgam_cfg_mem.sv ----
/*
  Sixteen-byte configuration field store with registered read data.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "fgam_regs.svh"

module fgam_cfg_mem
  import fgam_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  // Byte array, erased after reset
  logic [7:0] mem_reg [DEPTH];

  // ----------------------------------------------------------------
  // Storage and read register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= `FGAM_ERASED;
      end
      rd_data_o <= `FGAM_ERASED;
    end else begin
      if (wr_en_i) begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule : fgam_cfg_mem

// ---- verilog/fgam_decode.sv ----
/*
  Global address decoder for program flash, data flash and scratch RAM,
  with protection checks and the configuration field store.
  Assumes requests arrive on ref_clk_i from logic in the same domain.
*/
`timescale 1ns/1ns
`include "fgam_regs.svh"

module fgam_decode
  import fgam_pkg::*;
#(
  parameter int LO_UNIT = 1024,
  parameter int HI_UNIT = 2048
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire fgam_req_t req_i,
  input wire fgam_vis_t memory_map_control_one_i,
  input wire logic [7:0] pflash_protect_reg_i,
  output fgam_hit_t hit_o,
  output logic ack_o,
  output logic write_ignored_o,
  output logic prot_viol_o,
  output logic cfg_write_o,
  output logic [7:0] cfg_rdata_o,
  output logic [7:0] pflash_protect_default_o,
  output logic [7:0] dflash_protect_default_o,
  output logic [7:0] nonvolatile_option_o,
  output logic [7:0] security_setting_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fgam_hit_t hit;
    logic ack;
    logic wr_ign;
    logic viol;
    logic cfg_wr;
    logic [7:0] pprot;
    logic [7:0] dprot;
    logic [7:0] opt;
    logic [7:0] sec;
  } fgam_state_t;

  fgam_state_t st_reg;
  fgam_state_t st_next;
  fgam_hit_t hit_c;       // Combinational decode of this request
  logic prot_c;           // Request lands in an active region
  logic cfg_wr_c;         // Program into configuration field
  logic [7:0] mem_rdata;  // Registered configuration read data

  // Inclusive range test
  function automatic logic in_rng(input logic [22:0] a,
                                  input logic [22:0] lo,
                                  input logic [22:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // Protection check over the 64 KB program flash offset
  function automatic logic prot_chk(input logic [15:0] ofs,
                                    input logic [7:0] fp);
    logic [16:0] lo_end;
    logic [16:0] hi_start;
    logic in_lo;
    logic in_hi;
    lo_end = `FGAM_PF_LO_BASE
           + (17'(LO_UNIT) << fp[`FGAM_FP_LS_HI:`FGAM_FP_LS_LO]);
    hi_start = `FGAM_PF_END
             - (17'(HI_UNIT) << fp[`FGAM_FP_HS_HI:`FGAM_FP_HS_LO]);
    in_lo = ({1'b0, ofs} >= `FGAM_PF_LO_BASE)
          && ({1'b0, ofs} < lo_end);
    in_hi = {1'b0, ofs} >= hi_start;
    if (in_lo) begin
      prot_chk = !fp[`FGAM_FP_LDIS];
    end else if (in_hi) begin
      prot_chk = !fp[`FGAM_FP_HDIS];
    end else begin
      prot_chk = !fp[`FGAM_FP_OPEN];
    end
  endfunction : prot_chk

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    hit_c = '0;
    hit_c.pflash = in_rng(req_i.addr, `FGAM_PF_BASE, `FGAM_PF_TOP);
    hit_c.cfg = in_rng(req_i.addr, `FGAM_CFG_BASE, `FGAM_CFG_TOP);
    hit_c.pgm_ifr = memory_map_control_one_i.program_info_row_visible
      && in_rng(req_i.addr, `FGAM_PIF_BASE, `FGAM_PIF_TOP);
    hit_c.pgm_once = hit_c.pgm_ifr
      && in_rng(req_i.addr, `FGAM_ONCE_BASE, `FGAM_ONCE_TOP);
    hit_c.dflash = in_rng(req_i.addr, `FGAM_DF_BASE, `FGAM_DF_TOP);
    hit_c.dflash_ifr = memory_map_control_one_i.dflash_info_row_visible
      && in_rng(req_i.addr, `FGAM_DIF_BASE, `FGAM_DIF_TOP);
    hit_c.scratch = memory_map_control_one_i.scratch_ram_visible
      && in_rng(req_i.addr, `FGAM_RAM_BASE, `FGAM_RAM_TOP);
    // Reserved spans count as unmapped
    hit_c.unmapped = !(hit_c.pflash || hit_c.pgm_ifr || hit_c.dflash
      || hit_c.dflash_ifr || hit_c.scratch);
  end

  // Protection and configuration write qualification
  always_comb begin
    prot_c = hit_c.pflash && prot_chk(req_i.addr[15:0], pflash_protect_reg_i);
    cfg_wr_c = req_i.valid && req_i.prog && hit_c.cfg && !prot_c;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ack = req_i.valid;
    st_next.hit = req_i.valid ? hit_c : '0;
    // Plain writes to unmapped space do nothing but report
    st_next.wr_ign = req_i.valid && req_i.write && hit_c.unmapped;
    st_next.viol = req_i.valid && req_i.prog && prot_c;
    st_next.cfg_wr = cfg_wr_c;
    // Shadow copies of the defaults kept in the field
    if (cfg_wr_c) begin
      case (req_i.addr[3:0])
        `FGAM_OFS_PPROT: st_next.pprot = req_i.wdata;
        `FGAM_OFS_DPROT: st_next.dprot = req_i.wdata;
        `FGAM_OFS_OPT: st_next.opt = req_i.wdata;
        `FGAM_OFS_SEC: st_next.sec = req_i.wdata;
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{hit: '0, ack: 1'b0, wr_ign: 1'b0, viol: 1'b0,
                  cfg_wr: 1'b0, pprot: `FGAM_ERASED, dprot: `FGAM_ERASED,
                  opt: `FGAM_ERASED, sec: `FGAM_ERASED};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration field store, key included
  // ----------------------------------------------------------------
  fgam_cfg_mem #(
    .DEPTH(16)
  ) u_cfg_mem (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(cfg_wr_c),
    .wr_addr_i(req_i.addr[3:0]),
    .wr_data_i(req_i.wdata),
    .rd_addr_i(req_i.addr[3:0]),
    .rd_data_o(mem_rdata)
  );

  // Outputs straight from flip-flops
  assign hit_o = st_reg.hit;
  assign ack_o = st_reg.ack;
  assign write_ignored_o = st_reg.wr_ign;
  assign prot_viol_o = st_reg.viol;
  assign cfg_write_o = st_reg.cfg_wr;
  assign cfg_rdata_o = mem_rdata;
  assign pflash_protect_default_o = st_reg.pprot;
  assign dflash_protect_default_o = st_reg.dprot;
  assign nonvolatile_option_o = st_reg.opt;
  assign security_setting_o = st_reg.sec;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_pf_hit;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.valid |=> (hit_o.pflash == ($past(req_i.addr) >= 23'h7F0000));
  endproperty
  a_pf_hit: assert property (p_pf_hit)
    else $error("program flash hit wrong");

  property p_df_hit;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.addr[22:12] == 11'h100) |=> hit_o.dflash;
  endproperty
  a_df_hit: assert property (p_df_hit)
    else $error("data flash not decoded");

  property p_df_rsv;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.addr > 23'h100FFF && req_i.addr <= 23'h11FFFF)
      |=> hit_o.unmapped && !hit_o.dflash;
  endproperty
  a_df_rsv: assert property (p_df_rsv)
    else $error("reserved data span decoded");

  property p_dif_vis;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    hit_o.dflash_ifr
      |-> $past(memory_map_control_one_i.dflash_info_row_visible);
  endproperty
  a_dif_vis: assert property (p_dif_vis)
    else $error("info row seen while hidden");

  property p_ram_vis;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    hit_o.scratch |-> $past(memory_map_control_one_i.scratch_ram_visible)
      && $past(req_i.addr) >= 23'h123D00;
  endproperty
  a_ram_vis: assert property (p_ram_vis)
    else $error("scratch RAM seen while hidden");

  property p_pif_vis;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (hit_o.pgm_ifr || hit_o.pgm_once)
      |-> $past(memory_map_control_one_i.program_info_row_visible);
  endproperty
  a_pif_vis: assert property (p_pif_vis)
    else $error("program info row seen while hidden");

  property p_once;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    hit_o.pgm_once |-> $past(req_i.addr[22:6]) == 17'h10004;
  endproperty
  a_once: assert property (p_once)
    else $error("program once field misplaced");

  property p_ign;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    write_ignored_o |-> hit_o.unmapped && !cfg_write_o
      && $stable({pflash_protect_default_o, dflash_protect_default_o,
                  nonvolatile_option_o, security_setting_o});
  endproperty
  a_ign: assert property (p_ign)
    else $error("ignored write had effect");

  property p_viol;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    prot_viol_o |-> !cfg_write_o && hit_o.pflash
      && $stable({pflash_protect_default_o, dflash_protect_default_o,
                  nonvolatile_option_o, security_setting_o});
  endproperty
  a_viol: assert property (p_viol)
    else $error("protected program modified array");

  property p_sec;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (cfg_wr_c && req_i.addr[3:0] == 4'hF)
      |=> security_setting_o == $past(req_i.wdata);
  endproperty
  a_sec: assert property (p_sec)
    else $error("security byte not captured");

endmodule : fgam_decode

// ---- dv/fgam_cpu_model.sv ----
/*
  CPU side request model for the flash address decoder.
  Assumes the bench calls its tasks just after a clock edge.
*/
`timescale 1ns/1ns

module fgam_cpu_model
  import fgam_pkg::*;
(
  input wire logic ref_clk_i,
  output fgam_req_t req_o
);
  // ---------------------------------
  // Bus cycles
  // ---------------------------------
  initial req_o = '0;

  // One request; valid stays up so calls run back to back
  task automatic issue(input logic wr, pg, input logic [22:0] a,
                       input logic [7:0] d);
    req_o <= '{1'b1, wr, pg, a, d};
    @(posedge ref_clk_i);
    #1;
  endtask : issue

  // Idle cycles; released fields churn every cycle
  task automatic idle(input int n);
    repeat (n) begin
      req_o <= {1'b0, 33'($urandom)};
      @(posedge ref_clk_i);
      #1;
    end
  endtask : idle
endmodule : fgam_cpu_model

// ---- dv/fgam_decode_tb.sv ----
/*
  Self-checking bench for the flash address decoder.
  Assumes fgam_pkg and the CPU model are compiled first.
*/
`timescale 1ns/1ns

module fgam_decode_tb
  import fgam_pkg::*;
;
  localparam int LO = 1024;
  localparam int HI = 2048;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  fgam_req_t req;
  fgam_vis_t vis = '0;
  logic [7:0] fp = 8'hFF;
  fgam_hit_t hit;
  logic ack, ign, pv, cw;
  logic [7:0] rd, d_p, d_d, d_o, d_s;
  logic [7:0] mem [16];
  logic [22:0] b [3];
  int miscompares = 0;
  int n_checks = 0;
  // Window edges, inside and outside
  logic [22:0] tbl [27] = '{23'h7EFFFF, 23'h7F0000, 23'h7FFFFF,
    23'h7FFEFF, 23'h7FFF00, 23'h7FFF0F, 23'h7FFF10, 23'h3FFFFF,
    23'h400000, 23'h4000FF, 23'h400100, 23'h40013F, 23'h400140,
    23'h4001FF, 23'h400200, 23'h0FFFFF, 23'h100000, 23'h100FFF,
    23'h101000, 23'h11FFFF, 23'h120000, 23'h12007F, 23'h120080,
    23'h123CFF, 23'h123D00, 23'h123FFF, 23'h124000};

  initial forever #2 ref_clk_i = ~ref_clk_i;

  fgam_cpu_model i_fgam_cpu_model (.ref_clk_i(ref_clk_i), .req_o(req));

  fgam_decode #(.LO_UNIT(LO), .HI_UNIT(HI)) i_fgam_decode (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .memory_map_control_one_i(vis), .pflash_protect_reg_i(fp),
    .hit_o(hit), .ack_o(ack), .write_ignored_o(ign), .prot_viol_o(pv),
    .cfg_write_o(cw), .cfg_rdata_o(rd), .pflash_protect_default_o(d_p),
    .dflash_protect_default_o(d_d), .nonvolatile_option_o(d_o),
    .security_setting_o(d_s));

  // ---------------------------------
  // Reference model and checks
  // ---------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic fgam_hit_t exp_hit(input logic [22:0] a);
    fgam_hit_t h;
    h = '0;
    h.pflash = a >= 23'h7F0000;
    h.cfg = a >= 23'h7FFF00 && a <= 23'h7FFF0F;
    h.pgm_ifr = vis.program_info_row_visible && a >= 23'h400000 &&
                a <= 23'h4001FF;
    h.pgm_once = h.pgm_ifr && a >= 23'h400100 && a <= 23'h40013F;
    h.dflash = a >= 23'h100000 && a <= 23'h100FFF;
    h.dflash_ifr = vis.dflash_info_row_visible && a >= 23'h120000 &&
                   a <= 23'h12007F;
    h.scratch = vis.scratch_ram_visible && a >= 23'h123D00 &&
                a <= 23'h123FFF;
    h.unmapped = !(|h[7:1]);
    return h;
  endfunction : exp_hit

  // Protected program flash address under the live byte
  function automatic logic exp_viol(input logic [22:0] a);
    int o;
    logic l, h;
    o = int'(a[15:0]);
    l = o >= 'h8000 && o < 'h8000 + (LO << fp[1:0]);
    h = o >= 'h10000 - (HI << fp[4:3]);
    // Outside both regions is the third region, wherever it lies
    return a >= 23'h7F0000 && (l ? !fp[2] : (h ? !fp[5] : !fp[7]));
  endfunction : exp_viol

  // Issue one request and compare every result a cycle later, read data on config reads and plain config writes only
  task automatic rq(input logic wr, pg, input logic [22:0] a,
                    input logic [7:0] d);
    fgam_hit_t h;
    logic v;
    h = exp_hit(a);
    v = pg && exp_viol(a);
    i_fgam_cpu_model.issue(wr, pg, a, d);
    chk(ack, 1'b1);
    chk(hit, h);
    chk(ign, wr && h.unmapped);
    chk(pv, v);
    chk(cw, pg && h.cfg && !v);
    if (h.cfg && !pg)
      chk(rd, mem[a[3:0]]);
    if (pg && h.cfg && !v)
      mem[a[3:0]] = d;
    chk({d_p, d_d}, {mem[12], mem[13]});
    chk({d_o, d_s}, {mem[14], mem[15]});
  endtask : rq

  task automatic rst();
    rst_n_i = 1'b0;
    i_fgam_cpu_model.idle(6);
    rst_n_i = 1'b1;
    foreach (mem[i]) mem[i] = 8'hFF;
    chk({hit, ack, ign, pv, cw}, '0);
    chk(rd, 8'hFF);
    chk({d_p, d_d, d_o, d_s}, 32'hFFFFFFFF);
  endtask : rst

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // ---------------------------------
  // Scenarios
  // ---------------------------------
  initial begin
    void'($urandom(10));
    rst();
    // Every window edge under every visibility mix
    foreach (tbl[i]) for (int v = 0; v < 8; v++) begin
      vis = 3'(v);
      rq(1'b0, 1'b0, tbl[i], 8'h00);
    end
    // Plain writes, config field included, never stored
    repeat (100) begin
      vis = 3'($urandom);
      rq(1'b1, 1'b0, tbl[$urandom % 27] + 23'($urandom % 2), 8'($urandom));
    end
    // Key bytes, then the last phrase whole with erased reserved bytes
    for (int i = 0; i < 16; i++)
      rq(1'b0, 1'b1, 23'h7FFF00 + 23'(i),
         (i > 7 && i < 12) ? 8'hFF : 8'($urandom));
    for (int i = 0; i < 16; i++)
      rq(1'b0, 1'b0, 23'h7FFF00 + 23'(i), 8'h00);
    // Region edges for random protection settings
    repeat (64) begin
      fp = {1'b1, 7'($urandom)};
      b = '{23'h7F8000 + 23'(LO << fp[1:0]),
            23'h7FFFFF - 23'((HI << fp[4:3]) - 1), 23'h7F8000};
      foreach (b[j]) begin
        rq(1'b0, 1'b1, b[j] - 23'h1, 8'h00);
        rq(1'b0, 1'b1, b[j], 8'h00);
      end
      fp = {1'b0, 7'($urandom)};
      rq(1'b0, 1'b1, 23'h7F0000 + 23'($urandom % 'h10000), 8'h00);
    end
    // Boot loader into the unlocked higher region, then locked
    fp = 8'hFF;
    rq(1'b0, 1'b1, 23'h7FFFFE, 8'h00);
    fp = 8'hDF;
    rq(1'b0, 1'b1, 23'h7FFFFE, 8'h00);
    // Protected config byte keeps its value
    fp = 8'h80;
    rq(1'b0, 1'b1, 23'h7FFF0F, 8'h00);
    // Reset in mid-run clears the store
    rst();
    rq(1'b0, 1'b0, 23'h7FFF03, 8'h00);
    print_verdict();
  end

  // Hang guard
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
endmodule : fgam_decode_tb
